// File: inc/omsc_pkg.sv
// Package of constants and types for the operating mode and state controller
package omsc_pkg;

  // ----------------------------------------------------------------------
  // Operating mode, decoded from {mode_strap_high, mode_strap_low}
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    OMSC_MODE_RESERVED,
    OMSC_MODE_DEBUG,
    OMSC_MODE_PROGRAM,
    OMSC_MODE_NORMAL
  } omsc_mode_type;

  localparam logic [1:0] STRAP_DEBUG = 2'h1;
  localparam logic [1:0] STRAP_PROGRAM = 2'h2;
  localparam logic [1:0] STRAP_NORMAL = 2'h3;

  // ----------------------------------------------------------------------
  // Device states in normal mode
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    OMSC_ST_INIT,
    OMSC_ST_RUN,
    OMSC_ST_CPU_IDLE,
    OMSC_ST_POWERDOWN,
    OMSC_ST_THERMAL_SHUTDOWN
  } omsc_state_type;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLOCK_FREQ_HZ = 125000000;
  localparam int WAKE_CLOCK_HZ = 4000;
  localparam int WAKE_DIV_CYCLES = CLOCK_FREQ_HZ / WAKE_CLOCK_HZ;
  localparam int STRAP_HOLD_MS = 256;
  localparam longint STRAP_HOLD_CYCLES = 64'(CLOCK_FREQ_HZ) * STRAP_HOLD_MS / 1000;
  localparam int BOOT_TICKS = 1;

  // ----------------------------------------------------------------------
  // Power domain vector positions (one bit per block)
  // ----------------------------------------------------------------------
  localparam int DOM_COUNT = 12;
  localparam int DOM_REGULATOR = 0;
  localparam int DOM_CPU = 1;
  localparam int DOM_DATA_RAM = 2;
  localparam int DOM_FLASH = 3;
  localparam int DOM_ROM = 4;
  localparam int DOM_PERIPH = 5;
  localparam int DOM_TIMERS = 6;
  localparam int DOM_XTAL = 7;
  localparam int DOM_RC_2M = 8;
  localparam int DOM_RF_TX = 9;
  localparam int DOM_RETENTION_RAM = 10;
  localparam int DOM_LF_RECEIVER = 11;

  // Block condition classes
  typedef enum logic [1:0] {
    OMSC_COND_UNSUPPLIED,
    OMSC_COND_INACTIVE,
    OMSC_COND_ACTIVE
  } omsc_cond_type;

  localparam logic [DOM_COUNT-1:0] SUPPLY_ALL = 12'hFFF;
  localparam logic [DOM_COUNT-1:0] SUPPLY_RESET = 12'h000;

endpackage : omsc_pkg

// File: core/omsc_sync.sv
// Two-flop synchroniser bank for asynchronous inputs
`timescale 1ns/100ps
`default_nettype none

module omsc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock, // System clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [WIDTH-1:0] async_in, // Unsynchronised inputs
  output logic [WIDTH-1:0] sync_out // Synchronised inputs
);

  logic [WIDTH-1:0] stage1;

  // ----------------------------------------------------------------------
  // One pair of flops per bit
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          stage1[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          stage1[i] <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule : omsc_sync

`default_nettype wire

// File: core/omsc_ctrl.sv
// Operating mode latch and normal-mode device state controller
// Function
// - Latch mode straps at power-on reset release
// - Decode straps: debug, program, normal, reserved
// - Five states: init, run, idle, powerdown, shutdown
// - System reset forces init state
// - Idle gates CPU clock; interrupts resume run
// - Powerdown halts CPU until wake event
// - Shutdown: apply threshold, then wake-timer reset
// - Blocks active, inactive or unsupplied per state
// - Powerdown removes supply; retention RAM kept
// - Only retention RAM stays; LF receiver selectable
// - Only run accepts firmware transition requests
// - Other states leave on hardware events
// - Wake logic ticks at 4 kHz rate
// - Only power-on/brown-out re-read mode straps
`timescale 1ns/100ps
`default_nettype none

module omsc_ctrl (
  input wire logic clock, // 125 MHz clock
  input wire logic rst, // Power-on reset, asynchronous, active high
  input wire logic brownout, // Brown-out detect pin, active high
  input wire logic mode_strap_low, // Low mode strap pin
  input wire logic mode_strap_high, // High mode strap pin
  input wire logic soft_reset, // Software reset pulse, same domain
  input wire logic req_idle, // Firmware request to enter CPU idle
  input wire logic req_powerdown, // Firmware request to enter powerdown
  input wire logic req_shutdown, // Firmware request to enter shutdown
  input wire logic [1:0] overtemp_threshold, // Threshold to apply on shutdown
  input wire logic overtemp_enable_run, // Overtemp detector select in run/idle
  input wire logic lf_keep_on, // Keep LF receiver on in powerdown
  input wire logic periph_irq, // Enabled peripheral interrupt, level
  input wire logic wake_event, // Unmasked wake-up source, asynchronous
  input wire logic boot_done, // System controller finished boot
  output logic [1:0] operating_mode, // Latched operating mode
  output logic [2:0] device_state, // Current device state
  output logic cpu_clock_enable, // CPU clock gate
  output logic cpu_run, // Instruction execution allowed
  output logic [11:0] domain_supply, // Power per block, 1 = supplied
  output logic [11:0] domain_usable, // Usable per block, 1 = active
  output logic lowbat_enable, // Low battery monitor active
  output logic overtemp_limit_detector_enable, // Overtemp detector active
  output logic [1:0] overtemp_limit, // Applied overtemp threshold
  output logic wake_timer_reset, // Wake-up timer reset request
  output logic system_reset // System reset held to logic
);

  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------
  logic [3:0] sync_in;
  logic strap_low_s;
  logic strap_high_s;
  logic wake_s;
  logic brownout_s;

  omsc_sync #(.WIDTH(4)) u_sync (
    .clock(clock),
    .rst(rst),
    .async_in({brownout, wake_event, mode_strap_high, mode_strap_low}),
    .sync_out(sync_in)
  );

  assign strap_low_s = sync_in[0];
  assign strap_high_s = sync_in[1];
  assign wake_s = sync_in[2];
  assign brownout_s = sync_in[3];

  // ----------------------------------------------------------------------
  // Mode latch
  // ----------------------------------------------------------------------
  // Sampling is deferred past the synchroniser so the flops never see the
  // pins at reset; straps must be steady for their hold time anyway.
  logic [1:0] capture_count;
  logic mode_pending;
  omsc_pkg::omsc_mode_type mode;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      capture_count <= 2'h0;
      mode_pending <= 1'b1;
    end else if (brownout_s) begin
      capture_count <= 2'h0;
      mode_pending <= 1'b1;
    end else if (mode_pending) begin
      if (capture_count == 2'h3) begin
        mode_pending <= 1'b0;
      end else begin
        capture_count <= capture_count + 2'h1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode <= omsc_pkg::OMSC_MODE_RESERVED;
    end else if (mode_pending && capture_count == 2'h3) begin
      case ({strap_high_s, strap_low_s})
        omsc_pkg::STRAP_DEBUG: mode <= omsc_pkg::OMSC_MODE_DEBUG;
        omsc_pkg::STRAP_PROGRAM: mode <= omsc_pkg::OMSC_MODE_PROGRAM;
        omsc_pkg::STRAP_NORMAL: mode <= omsc_pkg::OMSC_MODE_NORMAL;
        default: mode <= omsc_pkg::OMSC_MODE_RESERVED;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // 4 kHz tick for the wake logic
  // ----------------------------------------------------------------------
  localparam logic [15:0] DIV_LAST = 16'(omsc_pkg::WAKE_DIV_CYCLES - 1);
  logic [15:0] div_count;
  logic wake_tick;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_count <= 16'h0000;
      wake_tick <= 1'b0;
    end else begin
      wake_tick <= (div_count == DIV_LAST);
      div_count <= (div_count == DIV_LAST) ? 16'h0000 : div_count + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Device state machine
  // ----------------------------------------------------------------------
  // Wake is sampled only on the slow tick, as the low-power logic would.
  // A wake level shorter than one tick period may be missed entirely.
  logic wake_seen;
  logic in_reset;
  logic [2:0] boot_count;
  omsc_pkg::omsc_state_type state;
  omsc_pkg::omsc_state_type next_state;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wake_seen <= 1'b0;
    end else begin
      wake_seen <= wake_tick && wake_s;
    end
  end

  assign in_reset = mode_pending || soft_reset || wake_timer_reset;

  always_comb begin
    next_state = state;
    case (state)
      omsc_pkg::OMSC_ST_INIT: begin
        if (!in_reset && mode == omsc_pkg::OMSC_MODE_NORMAL && boot_done &&
            boot_count == 3'(omsc_pkg::BOOT_TICKS)) begin
          next_state = omsc_pkg::OMSC_ST_RUN;
        end
      end
      omsc_pkg::OMSC_ST_RUN: begin
        if (req_shutdown) begin
          next_state = omsc_pkg::OMSC_ST_THERMAL_SHUTDOWN;
        end else if (req_powerdown) begin
          next_state = omsc_pkg::OMSC_ST_POWERDOWN;
        end else if (req_idle) begin
          next_state = omsc_pkg::OMSC_ST_CPU_IDLE;
        end
      end
      omsc_pkg::OMSC_ST_CPU_IDLE: begin
        if (periph_irq) begin
          next_state = omsc_pkg::OMSC_ST_RUN;
        end
      end
      omsc_pkg::OMSC_ST_POWERDOWN, omsc_pkg::OMSC_ST_THERMAL_SHUTDOWN: begin
        if (wake_seen) begin
          next_state = omsc_pkg::OMSC_ST_INIT;
        end
      end
      default: next_state = omsc_pkg::OMSC_ST_INIT;
    endcase
    // Supply, monitor, CPU gating, device_state and system_reset below follow this value,
    // so they all change on the edge that loads the state register.
    if (in_reset) begin
      next_state = omsc_pkg::OMSC_ST_INIT;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= omsc_pkg::OMSC_ST_INIT;
    end else if (in_reset) begin
      state <= omsc_pkg::OMSC_ST_INIT;
    end else begin
      state <= next_state;
    end
  end

  // Boot delay in slow ticks before init may hand over to run
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      boot_count <= 3'h0;
    end else if (state != omsc_pkg::OMSC_ST_INIT || in_reset) begin
      boot_count <= 3'h0;
    end else if (wake_tick && boot_count != 3'(omsc_pkg::BOOT_TICKS)) begin
      boot_count <= boot_count + 3'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Thermal shutdown entry: threshold first, wake-timer reset next cycle
  // ----------------------------------------------------------------------
  logic shutdown_armed;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      overtemp_limit <= 2'h0;
      shutdown_armed <= 1'b0;
      wake_timer_reset <= 1'b0;
    end else begin
      wake_timer_reset <= shutdown_armed;
      shutdown_armed <= 1'b0;
      if (state == omsc_pkg::OMSC_ST_RUN && req_shutdown && !in_reset) begin
        overtemp_limit <= overtemp_threshold;
        shutdown_armed <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Power map
  // ----------------------------------------------------------------------
  // Outside normal mode the chip is held awake with everything supplied.
  logic normal;
  logic low_power;
  logic [11:0] next_supply;
  logic [11:0] next_usable;

  assign normal = (mode == omsc_pkg::OMSC_MODE_NORMAL);
  assign low_power = normal && (next_state == omsc_pkg::OMSC_ST_POWERDOWN ||
                                next_state == omsc_pkg::OMSC_ST_THERMAL_SHUTDOWN);

  always_comb begin
    next_supply = omsc_pkg::SUPPLY_ALL;
    next_usable = omsc_pkg::SUPPLY_ALL;
    if (low_power) begin
      next_supply = omsc_pkg::SUPPLY_RESET;
      next_usable = omsc_pkg::SUPPLY_RESET;
      next_supply[omsc_pkg::DOM_RETENTION_RAM] = 1'b1;
      next_supply[omsc_pkg::DOM_LF_RECEIVER] = lf_keep_on;
      next_usable[omsc_pkg::DOM_LF_RECEIVER] = lf_keep_on;
    end else if (normal && next_state == omsc_pkg::OMSC_ST_CPU_IDLE) begin
      next_usable[omsc_pkg::DOM_CPU] = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      domain_supply <= omsc_pkg::SUPPLY_RESET;
      domain_usable <= omsc_pkg::SUPPLY_RESET;
    end else begin
      domain_supply <= next_supply;
      domain_usable <= next_usable;
    end
  end

  // Monitors drop with the supplies; the battery monitor has no select
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lowbat_enable <= 1'b0;
      overtemp_limit_detector_enable <= 1'b0;
    end else begin
      lowbat_enable <= !low_power;
      overtemp_limit_detector_enable <= !low_power && overtemp_enable_run;
    end
  end

  // ----------------------------------------------------------------------
  // CPU control and status
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cpu_clock_enable <= 1'b0;
      cpu_run <= 1'b0;
    end else begin
      cpu_clock_enable <= !in_reset && (!normal || next_state == omsc_pkg::OMSC_ST_RUN ||
                          next_state == omsc_pkg::OMSC_ST_INIT);
      cpu_run <= !in_reset && (!normal || next_state == omsc_pkg::OMSC_ST_RUN);
    end
  end

  // ----------------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      system_reset <= 1'b1;
      device_state <= 3'h0;
      operating_mode <= 2'h0;
    end else begin
      system_reset <= in_reset || (normal && next_state == omsc_pkg::OMSC_ST_INIT);
      device_state <= 3'(next_state);
      operating_mode <= 2'(mode);
    end
  end

endmodule : omsc_ctrl

`default_nettype wire

// File: verification/omsc_ctrl_checker.sv
// Assertion checker for the operating mode and state controller
`timescale 1ns/100ps
`default_nettype none

module omsc_ctrl_checker (
  input wire logic clock, // Clock
  input wire logic rst, // Power-on reset
  input wire logic brownout, // Brown-out
  input wire logic soft_reset, // Software reset
  input wire logic req_shutdown, // Shutdown request
  input wire logic lf_keep_on, // LF select
  input wire logic periph_irq, // Peripheral interrupt
  input wire logic wake_event, // Wake source
  input wire logic [1:0] operating_mode, // Mode
  input wire logic [2:0] device_state, // State
  input wire logic cpu_clock_enable, // CPU clock gate
  input wire logic cpu_run, // CPU execution
  input wire logic [11:0] domain_supply, // Supply map
  input wire logic [11:0] domain_usable, // Usable map
  input wire logic lowbat_enable, // Battery monitor
  input wire logic overtemp_limit_detector_enable, // Overtemp detector
  input wire logic wake_timer_reset, // Wake timer reset
  input wire logic system_reset // System reset
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Both inputs pass synchronisers, so effects lag by a few cycles
  logic [3:0] since_brownout;
  logic [3:0] wake_hist;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      since_brownout <= 4'h0;
    end else if (brownout) begin
      since_brownout <= 4'h0;
    end else if (since_brownout != 4'hF) begin
      since_brownout <= since_brownout + 4'h1;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wake_hist <= 4'h0;
    end else begin
      wake_hist <= {wake_hist[2:0], wake_event};
    end
  end
  sequence s_shut_request;
    device_state == 3'h1 && req_shutdown && !soft_reset;
  endsequence
  sequence s_reset_pulse;
    wake_timer_reset ##1 !wake_timer_reset;
  endsequence
  chk_reset_in_init: assert property (system_reset && operating_mode == 2'h3 |-> device_state == 3'h0)
    else $error("system reset outside init");
  chk_idle_clock_gated: assert property (device_state == 3'h2 |-> !cpu_clock_enable)
    else $error("cpu clock runs in idle");
  chk_irq_resumes_run: assert property (device_state == 3'h2 && periph_irq |-> ##[1:3] device_state == 3'h1)
    else $error("interrupt did not resume run");
  chk_powerdown_map: assert property (device_state == 3'h3 |-> !cpu_run && domain_supply[9:0] == 10'h000 && domain_supply[10] && !domain_usable[10])
    else $error("powerdown supply map wrong");
  chk_lf_selectable: assert property (device_state == 3'h3 && $stable(lf_keep_on) && $past(lf_keep_on, 2) == lf_keep_on |-> domain_supply[11] == lf_keep_on)
    else $error("lf domain ignores select");
  chk_monitors_off: assert property (device_state == 3'h3 |-> !lowbat_enable && !overtemp_limit_detector_enable)
    else $error("monitor active in powerdown");
  chk_shutdown_pulse: assert property (s_shut_request |-> ##[1:6] s_reset_pulse)
    else $error("no wake timer reset pulse");
  chk_pulse_to_init: assert property (wake_timer_reset && operating_mode == 2'h3 |-> ##[1:3] device_state == 3'h0)
    else $error("wake timer reset left init unreached");
  chk_run_only_exit: assert property (device_state == 3'h2 && !periph_irq && !soft_reset |=> device_state != 3'h3 && device_state != 3'h4)
    else $error("idle left for low power state");
  chk_powerdown_holds: assert property (device_state == 3'h3 && wake_hist == 4'h0 && !wake_event |=> device_state == 3'h3)
    else $error("powerdown left without wake");
  chk_mode_kept: assert property ($changed(operating_mode) |-> since_brownout < 4'hC)
    else $error("mode changed without power reset");
endmodule : omsc_ctrl_checker

bind omsc_ctrl omsc_ctrl_checker checker_inst (.clock, .rst, .brownout, .soft_reset, .req_shutdown,
  .lf_keep_on, .periph_irq, .wake_event, .operating_mode, .device_state, .cpu_clock_enable,
  .cpu_run, .domain_supply, .domain_usable, .lowbat_enable, .overtemp_limit_detector_enable,
  .wake_timer_reset, .system_reset);

`default_nettype wire

// File: verification/omsc_board.sv
// Board model: strap resistors and an on-chip wake source
`timescale 1ns/100ps
`default_nettype none

module omsc_board (
  input wire logic clock, // Clock
  input wire logic [1:0] strap_sel, // Strap pair {high, low}
  input wire logic wake_req, // Raise a wake event
  output logic mode_strap_low, // Low strap pin
  output logic mode_strap_high, // High strap pin
  output logic wake_event // Wake source, level
);
  // Straps move only when re-selected, never during a capture
  always_ff @(posedge clock) begin
    mode_strap_high <= strap_sel[1];
    mode_strap_low <= strap_sel[0];
  end
  // Held as a level, since the wake logic samples on a slow tick
  always_ff @(posedge clock) begin
    wake_event <= wake_req;
  end
endmodule : omsc_board

`default_nettype wire

// File: verification/operating_mode_state_control_test.sv
// Self-checking bench for the operating mode and state controller
`timescale 1ns/100ps
`default_nettype none

module operating_mode_state_control_test;
  typedef struct packed {
    logic [1:0] straps;
    logic [1:0] mode;
  } omsc_row_type;
  localparam omsc_row_type ROWS [4] = '{'{2'h0, 2'h0}, '{2'h1, 2'h1}, '{2'h2, 2'h2}, '{2'h3, 2'h3}};
  logic clock, rst, brownout, soft_reset, req_idle, req_powerdown, req_shutdown, periph_irq;
  logic overtemp_enable_run, lf_keep_on, boot_done, wake_req, mode_strap_low, mode_strap_high;
  logic wake_event, cpu_clock_enable, cpu_run, lowbat_enable, overtemp_limit_detector_enable;
  logic wake_timer_reset, system_reset;
  logic [1:0] overtemp_threshold, strap_sel, operating_mode, overtemp_limit;
  logic [2:0] device_state;
  logic [11:0] domain_supply, domain_usable;
  int errors, total_checks, cycles;

  omsc_ctrl dut (.clock, .rst, .brownout, .mode_strap_low, .mode_strap_high, .soft_reset,
    .req_idle, .req_powerdown, .req_shutdown, .overtemp_threshold, .overtemp_enable_run,
    .lf_keep_on, .periph_irq, .wake_event, .boot_done, .operating_mode, .device_state,
    .cpu_clock_enable, .cpu_run, .domain_supply, .domain_usable, .lowbat_enable,
    .overtemp_limit_detector_enable, .overtemp_limit, .wake_timer_reset, .system_reset);
  omsc_board board (.clock, .strap_sel, .wake_req, .mode_strap_low, .mode_strap_high, .wake_event);

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task tally_and_finish;
    $display("Checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // One-cycle strobes: brownout, soft reset, idle, powerdown, shutdown, irq
  localparam logic [5:0] PULSE_BROWNOUT = 6'h20;
  localparam logic [5:0] PULSE_SOFT = 6'h10;
  localparam logic [5:0] PULSE_IDLE = 6'h08;
  localparam logic [5:0] PULSE_POWERDOWN = 6'h04;
  localparam logic [5:0] PULSE_SHUTDOWN = 6'h02;
  localparam logic [5:0] PULSE_IRQ = 6'h01;

  task pulse(input logic [5:0] sel);
    @(posedge clock);
    {brownout, soft_reset, req_idle, req_powerdown, req_shutdown, periph_irq} <= sel;
    @(posedge clock);
    {brownout, soft_reset, req_idle, req_powerdown, req_shutdown, periph_irq} <= 6'h00;
  endtask : pulse

  task settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle

  // Booting from init waits for up to one slow tick, hence the large limits
  task wait_state(input logic [2:0] s, input int lim);
    int n;
    n = 0;
    do begin
      settle(1);
      n++;
    end while (device_state !== s && n < lim);
    check("device_state", 12'(device_state), 12'(s));
  endtask : wait_state

  always @(posedge clock) begin
    cycles++;
    if (cycles == 97000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    {rst, strap_sel, overtemp_enable_run, lf_keep_on} = 6'h3F;
    {brownout, soft_reset, req_idle, req_powerdown, req_shutdown, periph_irq} = 6'h00;
    {boot_done, wake_req, overtemp_threshold} = 4'h0;
    {errors, total_checks, cycles} = '0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      rst <= 1'b1;
      strap_sel <= ROWS[i].straps;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      settle(10);
      check("operating_mode", 12'(operating_mode), 12'(ROWS[i].mode));
      if (ROWS[i].mode != 2'h3) begin
        check("domain_supply", domain_supply, omsc_pkg::SUPPLY_ALL);
      end
      $display("Test mode row %0d done", i);
    end
    check("system_reset", 12'(system_reset), 12'h1);
    check("init state", 12'(device_state), 12'h0);
    @(posedge clock);
    boot_done <= 1'b1;
    wait_state(3'h1, 32000);
    check("cpu_run", 12'(cpu_run), 12'h1);
    check("system_reset", 12'(system_reset), 12'h0);
    check("monitors", 12'({lowbat_enable, overtemp_limit_detector_enable}), 12'h3);
    @(posedge clock);
    overtemp_enable_run <= 1'b0;
    settle(1);
    check("overtemp select", 12'(overtemp_limit_detector_enable), 12'h0);
    @(posedge clock);
    overtemp_enable_run <= 1'b1;
    pulse(PULSE_IDLE);
    wait_state(3'h2, 8);
    check("cpu_clock_enable", 12'(cpu_clock_enable), 12'h0);
    check("idle usable", domain_usable, 12'hFFD);
    pulse(PULSE_POWERDOWN);
    settle(4);
    check("idle refuses", 12'(device_state), 12'h2);
    pulse(PULSE_IRQ);
    wait_state(3'h1, 6);
    check("cpu_clock_enable", 12'(cpu_clock_enable), 12'h1);
    $display("Test idle done");
    pulse(PULSE_POWERDOWN);
    wait_state(3'h3, 8);
    check("domain_supply", domain_supply, 12'hC00);
    check("domain_usable", domain_usable, 12'h800);
    check("cpu_run", 12'(cpu_run), 12'h0);
    check("monitors", 12'({lowbat_enable, overtemp_limit_detector_enable}), 12'h0);
    @(posedge clock);
    lf_keep_on <= 1'b0;
    settle(2);
    check("lf off supply", domain_supply, 12'h400);
    check("lf off usable", domain_usable, 12'h000);
    @(posedge clock);
    lf_keep_on <= 1'b1;
    pulse(PULSE_IDLE);
    settle(4);
    check("powerdown holds", 12'(device_state), 12'h3);
    @(posedge clock);
    wake_req <= 1'b1;
    wait_state(3'h0, 40000);
    @(posedge clock);
    wake_req <= 1'b0;
    wait_state(3'h1, 32000);
    check("domain_supply", domain_supply, omsc_pkg::SUPPLY_ALL);
    $display("Test powerdown done");
    @(posedge clock);
    overtemp_threshold <= 2'h2;
    pulse(PULSE_SHUTDOWN);
    #1;
    check("overtemp_limit", 12'(overtemp_limit), 12'h2);
    check("reset after limit", 12'(wake_timer_reset), 12'h0);
    settle(1);
    check("wake_timer_reset", 12'(wake_timer_reset), 12'h1);
    check("shutdown state", 12'(device_state), 12'h4);
    settle(1);
    check("pulse width", 12'(wake_timer_reset), 12'h0);
    wait_state(3'h0, 6);
    $display("Test shutdown done");
    @(posedge clock);
    strap_sel <= 2'h1;
    pulse(PULSE_SOFT);
    settle(12);
    check("mode after soft reset", 12'(operating_mode), 12'h3);
    pulse(PULSE_BROWNOUT);
    settle(16);
    check("mode after brownout", 12'(operating_mode), 12'h1);
    $display("Test mode hold done");
    tally_and_finish();
  end
endmodule : operating_mode_state_control_test

`default_nettype wire
